// File: pkg/lfc_cfg.svh
// constants of the lane format and reset control block
`ifndef LFC_CFG_SVH
`define LFC_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define LFC_REG_FORMAT      5'h03
`define LFC_REG_RESET       5'h04
`define LFC_FORMAT_RST      16'h0180
`define LFC_RESET_RST       16'h0000
`define LFC_FORMAT_MASK     16'h1FFF

// ----------------------------------------
// lane_format_ctrl fields
// ----------------------------------------
`define LFC_F_COMMA         7
`define LFC_F_DDR           6
`define LFC_F_TX_ORDER      5
`define LFC_F_RX_ORDER      4
`define LFC_F_ENC           3
`define LFC_F_DEC           2
`define LFC_F_TX_EDGE       1
`define LFC_F_RX_EDGE       0

// ----------------------------------------
// lane_reset_ctrl fields
// ----------------------------------------
`define LFC_R_DATAPATH      3
`define LFC_R_TXQ           2
`define LFC_R_RXQ           1

// ----------------------------------------
// management frame
// ----------------------------------------
`define LFC_PHY_ADDR        5'h00
`define LFC_PRE_LEN         6'h20
`define LFC_HDR_LAST        5'h0B
`define LFC_DATA_LAST       5'h0F
`define LFC_OP_WRITE        2'h1
`define LFC_OP_READ         2'h2

`endif

// File: pkg/lfc_pkg.sv
// types of the lane format and reset control block
package lfc_pkg;

  typedef enum logic [2:0] {
    MS_IDLE,
    MS_START,
    MS_HDR,
    MS_TA,
    MS_DATA
  } lfc_mstate_t;

  typedef struct packed {
    logic        mdcS1;
    logic        mdcS2;
    logic        mdcPrev;
    logic        mdioS1;
    logic        mdioS2;
    lfc_mstate_t state;
    logic [5:0]  preCnt;
    logic [4:0]  bitCnt;
    logic [11:0] hdr;
    logic [15:0] shift;
    logic        taFirst;
    logic        mdioOut;
    logic        mdioOe;
    logic [15:0] format;
    logic [3:0]  resetBits;
    logic        dpTog;
    logic        txqTog;
    logic        rxqTog;
  } lfc_mgmt_t;

  typedef struct packed {
    logic [9:0]  cfgS1;
    logic [9:0]  cfgS2;
    logic [2:0]  togS1;
    logic [2:0]  togS2;
    logic [2:0]  togPrev;
    logic        pinS1;
    logic        pinS2;
    logic        dpRst;
    logic [19:0] txRise;
    logic [19:0] rxRise;
    logic [39:0] txSym;
    logic        txQuad;
    logic        commaOn;
    logic        encOn;
    logic        decOn;
    logic        txqClr;
    logic        rxqClr;
  } lfc_link_t;

  typedef struct packed {
    logic [19:0] txFall;
    logic [19:0] rxFall;
  } lfc_fall_t;

endpackage : lfc_pkg

// File: src/lfc_channel_datapath_control.sv
// lane format, codec enable and datapath reset control with management slave
// ----------------------------------------
// Functional notes
// - comma detection follows comma-enable bit; bit resets to one
// - comma detection forced on while jitter test pattern is verified
// - ddr bit zero moves words on one edge, one on both edges
// - tx order bit zero serializes upper symbol first, one lower first
// - rx order bit zero puts first symbol in upper half, one lower half
// - encoder active when encoder bit or coding pin is high
// - encoder forced on while jitter test pattern is generated
// - decoder active when decoder bit or coding pin is high
// - decoder forced on while jitter test pattern is verified
// - ddr tx: timing bit zero samples both edges, one makes own point; logic samples both edges for either value
// - sdr tx: timing zero samples rising edge, one samples falling edge
// - ddr rx: timing zero offsets output changes, one changes at edges; logic changes at edges for either value
// - sdr rx: timing zero aligns to falling edge, one to rising edge
// - datapath reset clears tx and rx paths, management registers kept
// - tx queue clear bit resets the transmit queue
// - rx queue clear bit resets the receive queue
// - reset bits clear themselves one mdc rising edge later
// - reset register reads zero after reset, format register its default
// ----------------------------------------
`include "lfc_cfg.svh"

module lfc_channel_datapath_control
  import lfc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        mdc,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioOe,
  input  wire logic        linkClk,
  input  wire logic        codecEnPin,
  input  wire logic        patternGenActive,
  input  wire logic        patternCheckActive,
  input  wire logic [19:0] txParWord,
  output logic      [39:0] txSymbolOut,
  output logic             txSymbolQuad,
  input  wire logic [39:0] rxSymbolIn,
  output logic      [19:0] rxParWord,
  output logic             commaDetectEn,
  output logic             encoderEn,
  output logic             decoderEn,
  output logic             txQueueClear,
  output logic             rxQueueClear
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // pair layout: [9:0] goes first on the line, [19:10] second
  function automatic logic [19:0] swapHalves(input logic [19:0] w, input logic keep);
    swapHalves = keep ? w : {w[9:0], w[19:10]};
  endfunction : swapHalves

  // ----------------------------------------
  // management domain
  // ----------------------------------------
  lfc_mgmt_t m;
  lfc_mgmt_t next_m;
  logic      mdcRise;
  logic      bitIn;

  assign mdcRise = m.mdcS2 & ~m.mdcPrev;
  assign bitIn   = m.mdioS2;

  always_comb begin
    next_m         = m;
    next_m.mdcS1   = mdc;
    next_m.mdcS2   = m.mdcS1;
    next_m.mdcPrev = m.mdcS2;
    next_m.mdioS1  = mdioIn;
    next_m.mdioS2  = m.mdioS1;
    if (mdcRise) begin
      // self clear one mdc edge later; a write below on this edge wins
      next_m.resetBits = 4'h0;
      case (m.state)
        MS_IDLE: begin
          next_m.mdioOe = 1'b0;
          if (bitIn) begin
            if (m.preCnt != `LFC_PRE_LEN) begin
              next_m.preCnt = m.preCnt + 6'h01;
            end
          end else begin
            if (m.preCnt == `LFC_PRE_LEN) begin
              next_m.state = MS_START;
            end
            next_m.preCnt = 6'h00;
          end
        end
        MS_START: begin
          next_m.bitCnt = 5'h00;
          next_m.state  = bitIn ? MS_HDR : MS_IDLE;
        end
        MS_HDR: begin
          next_m.hdr    = {m.hdr[10:0], bitIn};
          next_m.bitCnt = m.bitCnt + 5'h01;
          if (m.bitCnt == `LFC_HDR_LAST) begin
            next_m.state   = MS_TA;
            next_m.taFirst = 1'b1;
          end
        end
        MS_TA: begin
          next_m.taFirst = 1'b0;
          if (m.taFirst) begin
            // host has let go of the line; answer a read with the zero bit
            if ((m.hdr[11:10] == `LFC_OP_READ) && (m.hdr[9:5] == `LFC_PHY_ADDR)) begin
              next_m.mdioOe  = 1'b1;
              next_m.mdioOut = 1'b0;
              case (m.hdr[4:0])
                `LFC_REG_FORMAT: next_m.shift = m.format;
                `LFC_REG_RESET:  next_m.shift = {12'h000, m.resetBits};
                default:         next_m.shift = 16'h0000;
              endcase
            end
          end else begin
            next_m.state   = MS_DATA;
            next_m.bitCnt  = 5'h00;
            next_m.mdioOut = m.shift[15];
            next_m.shift   = m.mdioOe ? {m.shift[14:0], 1'b0} : m.shift;
          end
        end
        MS_DATA: begin
          next_m.bitCnt = m.bitCnt + 5'h01;
          if (m.mdioOe) begin
            next_m.mdioOut = m.shift[15];
            next_m.shift   = {m.shift[14:0], 1'b0};
          end else begin
            next_m.shift = {m.shift[14:0], bitIn};
          end
          if (m.bitCnt == `LFC_DATA_LAST) begin
            next_m.state  = MS_IDLE;
            next_m.preCnt = 6'h00;
            if (m.mdioOe) begin
              next_m.mdioOe = 1'b0;
            end else if ((m.hdr[11:10] == `LFC_OP_WRITE)
                         && (m.hdr[9:5] == `LFC_PHY_ADDR)) begin
              case (m.hdr[4:0])
                `LFC_REG_FORMAT: begin
                  next_m.format = {m.shift[14:0], bitIn} & `LFC_FORMAT_MASK;
                end
                `LFC_REG_RESET: begin
                  next_m.resetBits[`LFC_R_DATAPATH] = m.shift[`LFC_R_DATAPATH - 1];
                  next_m.resetBits[`LFC_R_TXQ]      = m.shift[`LFC_R_TXQ - 1];
                  next_m.resetBits[`LFC_R_RXQ]      = m.shift[`LFC_R_RXQ - 1];
                  // each one written to the datapath, tx queue or rx queue bit becomes an event for the link side
                  if (m.shift[`LFC_R_DATAPATH - 1]) begin
                    next_m.dpTog = ~m.dpTog;
                  end
                  if (m.shift[`LFC_R_TXQ - 1]) begin
                    next_m.txqTog = ~m.txqTog;
                  end
                  if (m.shift[`LFC_R_RXQ - 1]) begin
                    next_m.rxqTog = ~m.rxqTog;
                  end
                end
                default: begin
                end
              endcase
            end
          end
        end
        default: begin
          next_m.state  = MS_IDLE;
          next_m.mdioOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      m           <= '0;
      m.state     <= MS_IDLE;
      m.format    <= `LFC_FORMAT_RST;
      m.resetBits <= 4'(`LFC_RESET_RST);
    end else begin
      m <= next_m;
    end
  end

  assign mdioOut = m.mdioOut;
  assign mdioOe  = m.mdioOe;

  // ----------------------------------------
  // link domain, rising edge
  // ----------------------------------------
  // config bits are quasi static; software must follow a change with a
  // datapath reset, so a skewed two-flop crossing per bit is acceptable
  lfc_link_t l;
  lfc_link_t next_l;
  lfc_fall_t f;
  lfc_fall_t next_f;
  logic [9:0] cfg;
  logic       ddr;
  logic       txEdge;
  logic       rxEdge;
  logic [2:0] togEvt;

  assign cfg    = l.cfgS2;
  assign ddr    = cfg[`LFC_F_DDR];
  assign txEdge = cfg[`LFC_F_TX_EDGE];
  assign rxEdge = cfg[`LFC_F_RX_EDGE];
  assign togEvt = l.togS2 ^ l.togPrev;

  always_comb begin
    next_l         = l;
    next_l.cfgS1   = m.format[9:0];
    next_l.cfgS2   = l.cfgS1;
    next_l.togS1   = {m.dpTog, m.txqTog, m.rxqTog};
    next_l.togS2   = l.togS1;
    next_l.togPrev = l.togS2;
    next_l.pinS1   = codecEnPin;
    next_l.pinS2   = l.pinS1;
    next_l.dpRst   = togEvt[2];
    next_l.txqClr  = togEvt[2] | togEvt[1];
    next_l.rxqClr  = togEvt[2] | togEvt[0];
    next_l.commaOn = cfg[`LFC_F_COMMA] | patternCheckActive;
    next_l.encOn   = cfg[`LFC_F_ENC] | l.pinS2 | patternGenActive;
    next_l.decOn   = cfg[`LFC_F_DEC] | l.pinS2 | patternCheckActive;
    next_l.txQuad  = ddr;
    // rising capture: sdr falling-aligned source, or either ddr timing
    if (ddr || !txEdge) begin
      next_l.txRise = txParWord;
    end
    if (ddr) begin
      // order zero puts the upper symbol into [9:0], the slot sent first
      next_l.txSym = {swapHalves(f.txFall, cfg[`LFC_F_TX_ORDER]),
                      swapHalves(l.txRise, cfg[`LFC_F_TX_ORDER])};
    end else begin
      next_l.txSym = {20'h00000,
                      swapHalves(txEdge ? f.txFall : l.txRise,
                                 cfg[`LFC_F_TX_ORDER])};
    end
    if (ddr || rxEdge) begin
      next_l.rxRise = swapHalves(rxSymbolIn[19:0], cfg[`LFC_F_RX_ORDER]);
    end
    if (l.dpRst) begin
      // datapath only; management registers live in the other domain
      next_l.txRise = 20'h00000;
      next_l.rxRise = 20'h00000;
      next_l.txSym  = 40'h0000000000;
    end
  end

  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // ----------------------------------------
  // link domain, falling edge
  // ----------------------------------------
  always_comb begin
    next_f = f;
    if (ddr || txEdge) begin
      next_f.txFall = txParWord;
    end
    if (ddr) begin
      next_f.rxFall = swapHalves(rxSymbolIn[39:20], cfg[`LFC_F_RX_ORDER]);
    end else if (!rxEdge) begin
      next_f.rxFall = swapHalves(rxSymbolIn[19:0], cfg[`LFC_F_RX_ORDER]);
    end
    if (l.dpRst) begin
      next_f = '0;
    end
  end

  always_ff @(negedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // ddr output follows the edge just passed; the offset of the centred
  // timing is a pad delay and is not modelled here
  always_comb begin
    if (ddr) begin
      rxParWord = linkClk ? l.rxRise : f.rxFall;
    end else begin
      rxParWord = rxEdge ? l.rxRise : f.rxFall;
    end
  end

  assign txSymbolOut   = l.txSym;
  assign txSymbolQuad  = l.txQuad;
  assign commaDetectEn = l.commaOn;
  assign encoderEn     = l.encOn;
  assign decoderEn     = l.decOn;
  assign txQueueClear  = l.txqClr;
  assign rxQueueClear  = l.rxqClr;

endmodule : lfc_channel_datapath_control

// File: test/lfc_channel_datapath_control_monitor.sv
// assertion checker for the lane format and reset control block
module lfc_channel_datapath_control_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic linkClk,
  input wire logic mdioOut,
  input wire logic mdioOe,
  input wire logic codecEnPin,
  input wire logic patternGenActive,
  input wire logic patternCheckActive,
  input wire logic commaDetectEn,
  input wire logic encoderEn,
  input wire logic decoderEn,
  input wire logic txQueueClear,
  input wire logic rxQueueClear
);
  // ----------------
  // sequences
  // ----------------
  // pin crosses three flops to the output, so hold it long enough
  sequence pinHeld;
    codecEnPin [*4];
  endsequence
  sequence turnStart;
    $rose(mdioOe);
  endsequence
  // ----------------
  // link side
  // ----------------
  chk_comma_forced:
    assert property (@(posedge linkClk) disable iff (!arst_n)
      patternCheckActive |=> commaDetectEn) else $error("comma not forced");
  chk_enc_forced:
    assert property (@(posedge linkClk) disable iff (!arst_n)
      patternGenActive |=> encoderEn) else $error("encoder not forced");
  chk_dec_forced:
    assert property (@(posedge linkClk) disable iff (!arst_n)
      patternCheckActive |=> decoderEn) else $error("decoder not forced");
  chk_pin_codec:
    assert property (@(posedge linkClk) disable iff (!arst_n)
      pinHeld |=> encoderEn && decoderEn) else $error("pin ignored");
  chk_txq_pulse:
    assert property (@(posedge linkClk) disable iff (!arst_n)
      txQueueClear |=> !txQueueClear) else $error("tx clear too long");
  chk_rxq_pulse:
    assert property (@(posedge linkClk) disable iff (!arst_n)
      rxQueueClear |=> !rxQueueClear) else $error("rx clear too long");
  // ----------------
  // management side
  // ----------------
  chk_turn_zero:
    assert property (@(posedge clk) disable iff (!arst_n)
      turnStart |-> !mdioOut) else $error("turnaround not zero");
  chk_drive_span:
    assert property (@(posedge clk) disable iff (!arst_n)
      turnStart |-> mdioOe [*8]) else $error("read drive too short");
endmodule : lfc_channel_datapath_control_monitor

bind lfc_channel_datapath_control lfc_channel_datapath_control_monitor u_mon (
  .clk, .arst_n, .linkClk, .mdioOut, .mdioOe, .codecEnPin, .patternGenActive,
  .patternCheckActive, .commaDetectEn, .encoderEn, .decoderEn, .txQueueClear,
  .rxQueueClear
);

// File: test/lfc_par_partner.sv
// far-side parallel logic: launches transmit words, captures receive words
module lfc_par_partner (
  input  wire logic        linkClk,
  input  wire logic        alignRise,
  input  wire logic [19:0] word,
  input  wire logic [19:0] rxParWord,
  output logic      [19:0] txParWord,
  output logic      [19:0] rxGot
);
  timeunit 1ns;
  timeprecision 1ps;
  initial txParWord = 20'h00000;
  // launch opposite the device's sampling edge for half a cycle of margin
  always @(posedge linkClk) begin
    if (alignRise) txParWord <= word;
    if (!alignRise) rxGot <= rxParWord;
  end
  always @(negedge linkClk) begin
    if (!alignRise) txParWord <= word;
    if (alignRise) rxGot <= rxParWord;
  end
endmodule : lfc_par_partner

// File: test/lfc_channel_datapath_control_test.sv
// self-checking bench for the lane format and reset control block
`include "lfc_cfg.svh"
module lfc_channel_datapath_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, arst_n = 0, mdc = 0, linkClk = 0, hostEn = 0, hostBit = 1;
  logic        codecEnPin = 0, patternGenActive = 0, patternCheckActive = 0;
  logic        alignRise = 0, mdioOut, mdioOe, txSymbolQuad, commaDetectEn;
  logic        encoderEn, decoderEn, txQueueClear, rxQueueClear;
  logic [1:0]  qSeen = 0;
  logic [19:0] word = 0, txParWord, rxParWord, rxGot, ord;
  logic [39:0] rxSymbolIn = 0, txSymbolOut;
  logic [31:0] rnd = 32'h9474;
  logic [40:0] expQ[$], seenQ[$];
  int          err_total = 0, compares = 0;
  // pull-up on the shared management line
  wire         mdioWire = mdioOe ? mdioOut : (hostEn ? hostBit : 1'b1);

  always #5 clk = ~clk;
  initial begin
    #1.3;
    forever #40 linkClk = ~linkClk;
  end

  lfc_channel_datapath_control u_lfc_channel_datapath_control (
    .clk, .arst_n, .mdc, .mdioIn(mdioWire), .mdioOut, .mdioOe, .linkClk, .codecEnPin,
    .patternGenActive, .patternCheckActive, .txParWord, .txSymbolOut, .txSymbolQuad,
    .rxSymbolIn, .rxParWord, .commaDetectEn, .encoderEn, .decoderEn, .txQueueClear,
    .rxQueueClear
  );
  lfc_par_partner u_lfc_par_partner (
    .linkClk, .alignRise, .word, .rxParWord, .txParWord, .rxGot
  );

  // ----------------
  // helpers
  // ----------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [40:0] seen, input logic [40:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  always @(negedge clk) while (seenQ.size() > 0) check(seenQ.pop_front(), expQ.pop_front());
  // old value at the edge, so a one-cycle pulse is never missed
  always @(posedge linkClk) qSeen <= qSeen | {txQueueClear, rxQueueClear};
  task automatic lk(input int n);
    repeat (n) @(negedge linkClk);
    @(negedge clk);
  endtask : lk
  // host side: change as mdc falls, device samples on the mdc rise
  task automatic mbit(input logic b, output logic s);
    hostBit = b;
    mdc = 0;
    repeat (5) @(negedge clk);
    mdc = 1;
    s = mdioWire;
    repeat (5) @(negedge clk);
  endtask : mbit
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [45:0] h;
    logic        s;
    h = {32'hFFFFFFFF, 2'b01, op, `LFC_PHY_ADDR, ra};
    hostEn = 1;
    for (int i = 45; i >= 0; i--) mbit(h[i], s);
    hostEn = (op == `LFC_OP_WRITE);
    mbit(1'b1, s);
    mbit(1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      mbit(wd[i], s);
      rd[i] = s;
    end
    hostEn = 0;
  endtask : frame
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    frame(`LFC_OP_WRITE, ra, d, x);
  endtask : wr
  task automatic rdc(input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] x;
    frame(`LFC_OP_READ, ra, 16'h0000, x);
    expQ.push_back(e);
    seenQ.push_back(x);
  endtask : rdc
  task automatic finish_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  // ----------------
  // scenarios
  // ----------------
  initial begin
    repeat (12) @(negedge clk);
    arst_n = 1;
    rdc(`LFC_REG_FORMAT, `LFC_FORMAT_RST);
    rdc(`LFC_REG_RESET, `LFC_RESET_RST);
    rdc(5'h05, 16'h0000);
    rnd = lfsr(rnd);
    wr(`LFC_REG_FORMAT, rnd[15:0]);
    rdc(`LFC_REG_FORMAT, rnd[15:0] & `LFC_FORMAT_MASK);
    for (int i = 1; i <= 3; i++) begin
      qSeen = 0;
      wr(`LFC_REG_RESET, 16'h0001 << i);
      rdc(`LFC_REG_RESET, 16'h0000);
      expQ.push_back({i != 1, i != 2});
      seenQ.push_back(qSeen);
    end
    wr(`LFC_REG_FORMAT, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      {codecEnPin, patternGenActive, patternCheckActive} = k[2:0];
      lk(6);
      expQ.push_back({k[0], k[2] | k[1], k[2] | k[0]});
      seenQ.push_back({commaDetectEn, encoderEn, decoderEn});
    end
    {codecEnPin, patternGenActive, patternCheckActive} = 3'h0;
    wr(`LFC_REG_FORMAT, 16'h008C);
    lk(6);
    expQ.push_back(3'h7);
    seenQ.push_back({commaDetectEn, encoderEn, decoderEn});
    for (int m = 0; m < 8; m++) begin
      rnd = lfsr(rnd);
      alignRise = m[0];
      word = rnd[19:0];
      rxSymbolIn = {rnd[11:0], rnd[31:4]};
      wr(`LFC_REG_FORMAT, {9'h001, m[2], m[1], m[1], 2'b00, m[0], m[0]});
      wr(`LFC_REG_RESET, 16'h0008);
      lk(12);
      ord = m[1] ? word : {word[9:0], word[19:10]};
      expQ.push_back({m[2], m[2] ? ord : 20'h00000, ord});
      seenQ.push_back({txSymbolQuad, m[2] ? txSymbolOut[39:20] : 20'h00000, txSymbolOut[19:0]});
      if (!m[2]) begin
        expQ.push_back(m[1] ? rxSymbolIn[19:0] : {rxSymbolIn[9:0], rxSymbolIn[19:10]});
        seenQ.push_back(rxGot);
      end
    end
    lk(2);
    finish_test();
  end
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end
endmodule : lfc_channel_datapath_control_test
